// File: logic/load_shed_pkg.sv
// constants for the paired shed-and-restore control
package load_shed_pkg;
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] RTIME_ADDR = 4'h4;
	localparam logic [3:0] STAT_ADDR = 4'h8;
	localparam int CTRL_PAIR_EN = 0;
	localparam int CTRL_PERMIT = 1;
	localparam int CTRL_SHED_TYPE = 2;
	localparam int STAT_CCR = 0;
	localparam int STAT_OF = 1;
	localparam int STAT_BRK = 2;
	localparam int STAT_TCF = 3;
	localparam int RTIME_W = 16;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [RTIME_W-1:0] RTIME_RST = 16'h0000;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SHED = 2'b01,
		ST_RESTORE = 2'b10
	} shed_state_e;
endpackage : load_shed_pkg

// File: logic/load_shed_reclose_ctrl.sv
// paired shed-and-restore control for frequency elements number 1
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module load_shed_reclose_ctrl
	import load_shed_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic uf_operate,
	input wire logic roc_operate,
	input wire logic of_above_pickup,
	input wire logic of_below_reset,
	input wire logic [2:0] element_block_input,
	input wire logic breaker_open_input,
	input wire logic trip_circuit_failure,
	output logic open_cmd,
	output logic close_cmd,
	output logic close_cancelled_flag
);
	// element_block_input: bit0 underfrequency, bit1 rate, bit2 overfrequency
	logic [7:0] sync1;
	logic [7:0] sync2;
	logic init_prev;
	logic [2:0] ctrl;
	logic [RTIME_W-1:0] rtime;
	logic [RTIME_W-1:0] rcnt;
	shed_state_e state;
	logic uf_s;
	logic roc_s;
	logic above_s;
	logic below_s;
	logic [2:0] blk_s;
	logic brk_s;
	logic tcf_s;
	logic bus_go;
	logic wr_ok;
	logic permit;
	logic init_lvl;
	logic init_blk;
	logic shed_go;
	logic armed;
	logic restore_go;
	logic of_drop;

	// pins are asynchronous to ref_clk
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1 <= 8'h00;
			sync2 <= 8'h00;
		end else begin
			sync1 <= {trip_circuit_failure, breaker_open_input, element_block_input,
				of_below_reset, of_above_pickup, uf_operate};
			sync2 <= sync1;
		end
	end

	// rate operate travels in its own stage pair
	logic roc_m;
	logic roc_q;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			roc_m <= 1'b0;
			roc_q <= 1'b0;
		end else begin
			roc_m <= roc_operate;
			roc_q <= roc_m;
		end
	end

	assign uf_s = sync2[0];
	assign roc_s = roc_q;
	assign above_s = sync2[1];
	assign below_s = sync2[2];
	assign blk_s = sync2[5:3];
	assign brk_s = sync2[6];
	assign tcf_s = sync2[7];

	assign permit = ctrl[CTRL_PAIR_EN] && ctrl[CTRL_PERMIT];
	assign init_lvl = ctrl[CTRL_SHED_TYPE] ? roc_s : uf_s;
	assign init_blk = ctrl[CTRL_SHED_TYPE] ? blk_s[1] : blk_s[0];
	// edge of the initiator so a held trip gives one open only
	assign shed_go = (state == ST_IDLE) && permit && !init_blk
		&& init_lvl && !init_prev;
	assign armed = (state == ST_SHED) && brk_s && permit && !blk_s[2];
	// above_s is the element's operate level on the still-energised side
	assign restore_go = armed && above_s;
	assign of_drop = below_s && (rcnt >= rtime);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			init_prev <= 1'b0;
		end else begin
			init_prev <= init_lvl;
		end
	end

	// the single step: latch lives only in this state machine
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
		end else if (!ctrl[CTRL_PAIR_EN]) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (shed_go) begin
						state <= ST_SHED;
					end
				end
				ST_SHED: begin
					if (restore_go) begin
						state <= ST_RESTORE;
					end
				end
				ST_RESTORE: begin
					if (of_drop) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// reset timer of the paired overfrequency element
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rcnt <= RTIME_RST;
		end else if (state != ST_RESTORE || !below_s) begin
			rcnt <= RTIME_RST;
		end else if (rcnt != {RTIME_W{1'b1}}) begin
			rcnt <= rcnt + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			open_cmd <= 1'b0;
			close_cmd <= 1'b0;
		end else begin
			open_cmd <= shed_go;
			close_cmd <= restore_go && !tcf_s;
		end
	end

	// avalon slave: one wait state, write lands when waitrequest is low
	assign bus_go = (read || write) && waitrequest;
	assign wr_ok = write && !waitrequest;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= !bus_go;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl <= CTRL_RST;
			rtime <= RTIME_RST;
		end else if (wr_ok) begin
			if (address == CTRL_ADDR) begin
				ctrl <= writedata[2:0];
			end else if (address == RTIME_ADDR) begin
				rtime <= writedata[RTIME_W-1:0];
			end
		end
	end

	// set beats the write-one clear in the same cycle
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			close_cancelled_flag <= 1'b0;
		end else if (restore_go && tcf_s) begin
			close_cancelled_flag <= 1'b1;
		end else if (wr_ok && address == STAT_ADDR && writedata[STAT_CCR]) begin
			close_cancelled_flag <= 1'b0;
		end
	end

	// status shows no shed latch on purpose
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			readdata <= DATA_ZERO;
		end else if (bus_go && read) begin
			readdata <= DATA_ZERO;
			if (address == CTRL_ADDR) begin
				readdata[2:0] <= ctrl;
			end else if (address == RTIME_ADDR) begin
				readdata[RTIME_W-1:0] <= rtime;
			end else if (address == STAT_ADDR) begin
				readdata[STAT_CCR] <= close_cancelled_flag;
				readdata[STAT_OF] <= (state == ST_RESTORE);
				readdata[STAT_BRK] <= brk_s;
				readdata[STAT_TCF] <= tcf_s;
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	property p_open_once;
		open_cmd |=> !open_cmd;
	endproperty
	a_open_once: assert property (p_open_once) else $error("open longer than one cycle");

	property p_close_once;
		close_cmd |=> !close_cmd;
	endproperty
	a_close_once: assert property (p_close_once) else $error("close longer than one cycle");

	property p_open_perm;
		open_cmd |-> $past(permit) && !$past(init_blk);
	endproperty
	a_open_perm: assert property (p_open_perm) else $error("open without permission");

	property p_close_cond;
		close_cmd |-> $past(brk_s) && $past(permit) && state == ST_RESTORE;
	endproperty
	a_close_cond: assert property (p_close_cond) else $error("close without breaker open");

	property p_cancel;
		(restore_go && tcf_s) |=> close_cancelled_flag && !close_cmd;
	endproperty
	a_cancel: assert property (p_cancel) else $error("failed close not cancelled");

	property p_rearm;
		(state == ST_RESTORE && of_drop && ctrl[CTRL_PAIR_EN]) |=> state == ST_IDLE;
	endproperty
	a_rearm: assert property (p_rearm) else $error("no re-arm after reset time");

	property p_hold;
		(state == ST_RESTORE && !below_s && ctrl[CTRL_PAIR_EN]) |=> state == ST_RESTORE;
	endproperty
	a_hold: assert property (p_hold) else $error("overfrequency dropped early");

	property p_shed_open;
		shed_go |=> open_cmd && state == ST_SHED;
	endproperty
	a_shed_open: assert property (p_shed_open) else $error("shed without open pulse");

	property p_bus;
		bus_go |=> !waitrequest ##1 waitrequest;
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer not one wait state");

	// restore held back while the overfrequency side is not allowed to act
	property p_of_block;
		(state == ST_SHED && blk_s[2] && ctrl[CTRL_PAIR_EN]) |=> state == ST_SHED && !close_cmd;
	endproperty
	a_of_block: assert property (p_of_block) else $error("close while blocked");

	property p_no_brk;
		(state == ST_SHED && !brk_s && ctrl[CTRL_PAIR_EN]) |=> state == ST_SHED && !close_cmd;
	endproperty
	a_no_brk: assert property (p_no_brk) else $error("close with breaker closed");

	property p_pair_off;
		!ctrl[CTRL_PAIR_EN] |=> state == ST_IDLE;
	endproperty
	a_pair_off: assert property (p_pair_off) else $error("latch kept after disable");

	property p_ccf_sticky;
		(close_cancelled_flag && !(wr_ok && address == STAT_ADDR && writedata[STAT_CCR]))
			|=> close_cancelled_flag;
	endproperty
	a_ccf_sticky: assert property (p_ccf_sticky) else $error("cancel flag lost");

	property p_rcnt;
		(state == ST_RESTORE && below_s && rcnt < rtime && ctrl[CTRL_PAIR_EN])
			|=> state == ST_RESTORE;
	endproperty
	a_rcnt: assert property (p_rcnt) else $error("dropped before reset time");

	property p_open_state;
		open_cmd |-> state == ST_SHED;
	endproperty
	a_open_state: assert property (p_open_state) else $error("open without latch");

	c_shed: cover property (open_cmd);
	c_close: cover property (close_cmd);
	c_cancel: cover property ($rose(close_cancelled_flag));
	c_rate: cover property (shed_go && ctrl[CTRL_SHED_TYPE]);
	c_rearm: cover property (state == ST_RESTORE && of_drop);
endmodule : load_shed_reclose_ctrl

// File: test/breaker_model.sv
// breaker and trip-circuit model on the far side of the shed control
`timescale 1ns/1ps
module breaker_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic open_cmd,
	input wire logic close_cmd,
	input wire logic tcf_req,
	output logic breaker_open_input,
	output logic trip_circuit_failure
);
	logic [3:0] travel;
	// contacts take a few cycles to part, as a real breaker would
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			travel <= 4'h0;
			breaker_open_input <= 1'b0;
		end else begin
			travel <= {travel[2:0], open_cmd};
			if (travel[3])
				breaker_open_input <= 1'b1;
			else if (close_cmd)
				breaker_open_input <= 1'b0;
		end
	end
	assign trip_circuit_failure = tcf_req;
endmodule : breaker_model

// File: test/tb.sv
// self-checking bench for the shed-and-restore control
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb
	import load_shed_pkg::*;
;
	logic ref_clk = 0, sys_rst = 1, read = 0, write = 0;
	logic [3:0] address = 4'h0;
	logic [31:0] writedata = 32'h0, readdata, rd_v;
	logic waitrequest, uf = 0, roc = 0, of_up = 0, of_dn = 0, tcf_req = 0;
	logic [2:0] blk = 3'h0;
	logic brk, tcf, open_cmd, close_cmd, ccf;
	int n_errors = 0, n_tests = 0, n_open = 0, n_close = 0, o, c;
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		n_open += open_cmd;
		n_close += close_cmd;
	end
	load_shed_reclose_ctrl load_shed_reclose_ctrl_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .uf_operate(uf),
		.roc_operate(roc), .of_above_pickup(of_up), .of_below_reset(of_dn),
		.element_block_input(blk), .breaker_open_input(brk),
		.trip_circuit_failure(tcf), .open_cmd(open_cmd), .close_cmd(close_cmd),
		.close_cancelled_flag(ccf));
	breaker_model breaker_model_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.open_cmd(open_cmd), .close_cmd(close_cmd), .tcf_req(tcf_req),
		.breaker_open_input(brk), .trip_circuit_failure(tcf));
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : wt
	// request held until waitrequest sampled low, then released
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		address <= a;
		writedata <= d;
		read <= ~wr;
		write <= wr;
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		rd_v = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge ref_clk);
	endtask : bus
	task automatic shed(input logic u, input logic r, input int exp_n);
		o = n_open;
		uf <= u;
		roc <= r;
		wt(10);
		`CHK(n_open - o, exp_n)
		uf <= 1'b0;
		roc <= 1'b0;
		wt(3);
	endtask : shed
	task automatic recover(input int exp_n, input logic exp_f);
		c = n_close;
		of_up <= 1'b1;
		wt(10);
		`CHK(n_close - c, exp_n)
		`CHK(ccf, exp_f)
		of_up <= 1'b0;
		of_dn <= 1'b1;
		wt(12);
		of_dn <= 1'b0;
		wt(3);
	endtask : recover
	task automatic t_regs;
		bus(0, CTRL_ADDR, 0);
		`CHK(rd_v, DATA_ZERO)
		bus(0, STAT_ADDR, 0);
		`CHK(rd_v, DATA_ZERO)
		bus(0, 4'hc, 0);
		`CHK(rd_v, DATA_ZERO)
		bus(1, RTIME_ADDR, 32'h4);
		bus(0, RTIME_ADDR, 0);
		`CHK(rd_v, 32'h4)
	endtask : t_regs
	task automatic t_shed_close;
		bus(1, CTRL_ADDR, 32'h3);
		shed(1, 0, 1);
		`CHK(brk, 1'b1)
		bus(0, STAT_ADDR, 0);
		`CHK(rd_v, (32'h1 << STAT_BRK))
		recover(1, 1'b0);
		shed(1, 0, 1);
		recover(1, 1'b0);
	endtask : t_shed_close
	task automatic t_gates;
		c = n_close;
		of_up <= 1'b1;
		wt(10);
		`CHK(n_close - c, 0)
		of_up <= 1'b0;
		bus(1, CTRL_ADDR, 32'h1);
		shed(1, 0, 0);
		bus(1, CTRL_ADDR, 32'h3);
		blk <= 3'h1;
		shed(1, 0, 0);
		blk <= 3'h0;
	endtask : t_gates
	task automatic t_rate;
		bus(1, CTRL_ADDR, 32'h7);
		shed(1, 0, 0);
		blk <= 3'h2;
		shed(0, 1, 0);
		blk <= 3'h0;
		shed(0, 1, 1);
		blk <= 3'h4;
		recover(0, 1'b0);
		blk <= 3'h0;
		recover(1, 1'b0);
	endtask : t_rate
	task automatic t_tcf;
		bus(1, CTRL_ADDR, 32'h3);
		tcf_req <= 1'b1;
		shed(1, 0, 1);
		recover(0, 1'b1);
		bus(0, STAT_ADDR, 0);
		`CHK(rd_v[STAT_CCR], 1'b1)
		tcf_req <= 1'b0;
		bus(1, STAT_ADDR, 32'h1);
		`CHK(ccf, 1'b0)
	endtask : t_tcf
	task automatic end_of_test;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	initial begin
		wt(6);
		sys_rst <= 1'b0;
		wt(1);
		t_regs;
		t_shed_close;
		t_gates;
		t_rate;
		t_tcf;
		end_of_test;
	end
	// whole run is well under 1000 cycles
	initial begin
		#20000;
		n_errors++;
		end_of_test;
	end
endmodule : tb
